// ### dmace_pkg.sv
// Purpose: Shared constants and carriers of the four-channel transfer-enable control
// Assumes: One 50 MHz clock, synchronous active-high reset, classic Wishbone slave
// Notes:   Register word index is byte address bits 4:2
package dmace_pkg;

    // Channel count and bus widths
    localparam int unsigned DMACE_NUM_CH   = 4;
    localparam int unsigned DMACE_ADR_W    = 8;

    // Byte offsets of the register words
    localparam logic [7:0]  DMACE_OFS_CH0  = 8'h00; // Channel n at 8'h00 + 4*n
    localparam logic [7:0]  DMACE_OFS_STAT = 8'h10; // Sticky hardware-stop status
    localparam logic [7:0]  DMACE_OFS_MASK = 8'h14; // Interrupt mask

    // Field positions inside a channel mode control register
    localparam int unsigned DMACE_ENABLE_BIT = 31;
    localparam int unsigned DMACE_ACTIVE_BIT = 23;
    localparam int unsigned DMACE_SYSTEM_ERROR_FLAG_BIT   = 19;
    localparam int unsigned DMACE_MODE_LSB   = 12;
    localparam int unsigned DMACE_SRC_LSB    = 6;

    // Transfer mode field encodings
    localparam logic [1:0]  DMACE_MODE_NORMAL = 2'h0;
    localparam logic [1:0]  DMACE_MODE_BLOCK  = 2'h1;
    localparam logic [1:0]  DMACE_MODE_REPEAT = 2'h2;

    // Request source field encodings
    localparam logic [1:0]  DMACE_SRC_AUTO   = 2'h0;
    localparam logic [1:0]  DMACE_SRC_MODULE = 2'h1;
    localparam logic [1:0]  DMACE_SRC_EXT    = 2'h2;

    // Reset values
    localparam logic [1:0]  DMACE_MODE_RST = 2'h0;
    localparam logic [1:0]  DMACE_SRC_RST  = 2'h0;
    localparam logic [3:0]  DMACE_IRQ_RST  = 4'h0;

    // Software control for one channel; set and clear are one-cycle pulses, mode and source are levels
    typedef struct packed {
        logic       en_set;
        logic       en_clr;
        logic       block_mode;
        logic [1:0] src;
    } dmace_ctl_t;

    // Engine events for one channel, each a one-cycle pulse
    typedef struct packed {
        logic unit_done;  // One unit moved
        logic block_end;  // Current block finished
        logic total_end;  // Total size reached
        logic repeat_ovf; // Repeat or extended repeat overflow stop
        logic size_err;   // Transfer size error stop
        logic ext_stop;   // External stopping event
    } dmace_evt_t;

    // Channel sequencing states
    typedef enum logic [2:0] {
        DMACE_IDLE   = 3'b001,
        DMACE_WAIT   = 3'b010,
        DMACE_ACTIVE = 3'b100
    } dmace_state_t;

endpackage : dmace_pkg

// ### dmace_chan.sv
// Purpose: One channel's transfer-enable bit and active-state sequencing
// Assumes: Set, clear and event inputs are one-cycle pulses on clk_i; mode and source are levels
// Notes:   Hardware stops outrank any software write in the same cycle
`timescale 1ns/100ps
module dmace_chan
    import dmace_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Control from the register file, request, engine events and halt
    input  wire dmace_ctl_t ctl_i,
    input  wire logic       req_i,
    input  wire dmace_evt_t evt_i,
    input  wire logic       halt_i,
    // Status
    output logic            enable_o,
    output logic            active_o,
    output logic            stop_o
);

    typedef struct packed {
        dmace_state_t st;
        logic         enable;
        logic         pend_stop;
        logic         stop;
    } dmace_cst_t;

    dmace_cst_t s;
    dmace_cst_t next_s;
    logic       hw_clr;
    logic       is_auto;

    // Any hardware stopping condition
    assign hw_clr  = halt_i | evt_i.total_end | evt_i.repeat_ovf
                   | evt_i.size_err | evt_i.ext_stop;
    assign is_auto = (ctl_i.src == DMACE_SRC_AUTO);

    // Next-state: hardware clear first, then software, then sequencing
    always_comb begin
        next_s      = s;
        next_s.stop = 1'b0;
        if (hw_clr) begin
            next_s.enable    = 1'b0;
            next_s.pend_stop = 1'b0;
            next_s.st        = DMACE_IDLE;
            next_s.stop      = s.enable;
        end else if (ctl_i.en_clr && s.enable) begin
            if (ctl_i.block_mode && s.st == DMACE_ACTIVE) begin
                next_s.pend_stop = 1'b1;
            end else begin
                next_s.enable = 1'b0;
                next_s.st     = DMACE_IDLE;
            end
        end else if (ctl_i.en_set && !s.enable) begin
            next_s.enable = 1'b1;
            // Autorequest needs no request; others wait for one after the set
            next_s.st     = is_auto ? DMACE_ACTIVE : DMACE_WAIT;
        end else begin
            case (s.st)
                DMACE_WAIT: begin
                    if (req_i) begin
                        next_s.st = DMACE_ACTIVE;
                    end
                end
                DMACE_ACTIVE: begin
                    if (ctl_i.block_mode) begin
                        if (evt_i.block_end && s.pend_stop) begin
                            next_s.enable    = 1'b0;
                            next_s.pend_stop = 1'b0;
                            next_s.st        = DMACE_IDLE;
                        end else if (evt_i.block_end && !is_auto) begin
                            next_s.st = DMACE_WAIT;
                        end
                    end else if (evt_i.unit_done && !is_auto) begin
                        next_s.st = DMACE_WAIT;
                    end
                end
                DMACE_IDLE: begin
                    next_s.st = DMACE_IDLE;
                end
                default: begin
                    next_s.st = DMACE_IDLE;
                end
            endcase
        end
    end

    // State register; reset holds the enable at zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '{st: DMACE_IDLE, enable: 1'b0, pend_stop: 1'b0, stop: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign enable_o = s.enable;
    assign active_o = (s.st == DMACE_ACTIVE);
    assign stop_o   = s.stop;

    // Deferred clear in block mode: clear request while the channel is active, no hardware stop
    sequence s_defer_req;
        ctl_i.block_mode && active_o && ctl_i.en_clr && !hw_clr;
    endsequence

    a_hw_clear_prio: assert property (@(posedge clk_i) disable iff (srst_i)
        hw_clr |=> !enable_o && !active_o) else $error("hardware stop did not clear enable");
    a_auto_start: assert property (@(posedge clk_i) disable iff (srst_i)
        ctl_i.en_set && !enable_o && is_auto && !hw_clr && !ctl_i.en_clr
        |=> enable_o && active_o) else $error("autorequest did not start");
    a_req_start: assert property (@(posedge clk_i) disable iff (srst_i)
        ctl_i.en_set && !enable_o && !is_auto && !hw_clr && !ctl_i.en_clr
        |=> enable_o && !active_o) else $error("started without a later request");
    a_normal_stop: assert property (@(posedge clk_i) disable iff (srst_i)
        ctl_i.en_clr && enable_o && !ctl_i.block_mode && !hw_clr
        |=> !enable_o) else $error("clear did not stop channel");
    a_block_defer: assert property (@(posedge clk_i) disable iff (srst_i)
        s_defer_req |=> enable_o) else $error("block clear was not deferred");
    a_block_finish: assert property (@(posedge clk_i) disable iff (srst_i)
        s.pend_stop && evt_i.block_end && ctl_i.block_mode && !hw_clr
        |=> !enable_o ##1 !enable_o) else $error("deferred clear missed block end");
    a_active_enabled: assert property (@(posedge clk_i) disable iff (srst_i)
        active_o |-> enable_o) else $error("active without enable");
    a_stop_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
        hw_clr && enable_o |=> stop_o ##1 !stop_o) else $error("stop event not flagged");

endmodule : dmace_chan

// ### dmace_top.sv
// Purpose: Four-channel transfer-enable control with Wishbone registers and interrupt
// Assumes: Classic Wishbone master, engine events are one-cycle pulses
// Notes:   Ack comes one cycle after the request; writes land on the ack edge
`timescale 1ns/100ps
// Notes on behaviour
// - Bit 31 of each channel mode register enables transfers; resets to 0.
// - The enable bit reads 1 while the channel is in operation.
// - With autorequest, writing 1 starts transferring with no further request.
// - With module or external source, only a request after setting starts.
// - Outside block mode, writing 0 while moving data stops the channel.
// - In block mode, writing 0 takes effect after the current block ends.
// - An external stopping event clears the enable bit and stops the channel.
// - Reaching the total transfer size clears the enable bit.
// - Repeat or extended repeat overflow stop clears the enable bit.
// - A transfer size error stop clears the enable bit.
// - An address error or NMI request clears the enable bit.
// - Enable is held 0 during reset or hardware standby.
// - While the system error flag is 1, enable writes are ignored.
// - Read-only active bit is 1 only while the channel is active.
module dmace_top
    import dmace_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [DMACE_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // Transfer requests
    input  wire logic [DMACE_NUM_CH-1:0] module_req_i,
    input  wire logic [DMACE_NUM_CH-1:0] ext_req_i,
    // Engine and system events
    input  wire dmace_evt_t [DMACE_NUM_CH-1:0] evt_i,
    input  wire logic                    addr_err_i,
    input  wire logic                    nmi_i,
    input  wire logic                    standby_i,
    // Channel status and interrupt
    output logic [DMACE_NUM_CH-1:0]      chan_enable_o,
    output logic [DMACE_NUM_CH-1:0]      chan_active_o,
    output logic                         irq_o
);

    typedef struct packed {
        logic                        ack;
        logic [31:0]                 rdata;
        logic                        err_flag;
        logic [DMACE_NUM_CH-1:0]     irq_stat;
        logic [DMACE_NUM_CH-1:0]     irq_mask;
        logic [DMACE_NUM_CH-1:0][1:0] mode;
        logic [DMACE_NUM_CH-1:0][1:0] src;
    } dmace_regs_t;

    dmace_regs_t                  s;
    dmace_regs_t                  next_s;
    dmace_ctl_t [DMACE_NUM_CH-1:0] ctl;
    logic [DMACE_NUM_CH-1:0]      ch_req;
    logic [DMACE_NUM_CH-1:0]      ch_stop;
    logic [DMACE_NUM_CH-1:0]      wr_ch;
    logic                         req_new;
    logic                         wr_fire;
    logic [2:0]                   word_idx;
    logic                         sys_err;
    logic                         halt;

    // Word index of a byte address; out-of-range addresses map past the table
    function automatic logic [2:0] word_of(input logic [DMACE_ADR_W-1:0] adr);
        if (adr[DMACE_ADR_W-1:5] != '0) begin
            word_of = 3'h7;
        end else begin
            word_of = adr[4:2];
        end
    endfunction : word_of

    // Compose one readable word from the current state
    function automatic logic [31:0] read_word(input logic [2:0] idx,
                                               input dmace_regs_t r,
                                               input logic [DMACE_NUM_CH-1:0] en,
                                               input logic [DMACE_NUM_CH-1:0] act);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (idx < 3'(DMACE_NUM_CH)) begin
            w[DMACE_ENABLE_BIT]                 = en[idx[1:0]];
            w[DMACE_ACTIVE_BIT]                 = act[idx[1:0]];
            w[DMACE_MODE_LSB+1:DMACE_MODE_LSB]  = r.mode[idx[1:0]];
            w[DMACE_SRC_LSB+1:DMACE_SRC_LSB]    = r.src[idx[1:0]];
            if (idx == 3'h0) begin
                w[DMACE_SYSTEM_ERROR_FLAG_BIT] = r.err_flag;
            end
        end else if (idx == DMACE_OFS_STAT[4:2]) begin
            w[DMACE_NUM_CH-1:0] = r.irq_stat;
        end else if (idx == DMACE_OFS_MASK[4:2]) begin
            w[DMACE_NUM_CH-1:0] = r.irq_mask;
        end
        read_word = w;
    endfunction : read_word

    // Bus phase decode: take a new request, then fire it on the ack edge
    assign req_new  = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
    assign word_idx = word_of(wb_adr_i);
    assign sys_err  = addr_err_i | nmi_i;
    assign halt     = sys_err | standby_i;

    // Per-channel software pulses and request select
    always_comb begin
        for (int i = 0; i < DMACE_NUM_CH; i++) begin
            wr_ch[i]          = wr_fire && word_idx == 3'(i);
            // A write that sets enable starts with the mode and source it carries
            ctl[i].block_mode = ((wr_ch[i] && wb_sel_i[1])
                              ? wb_dat_i[DMACE_MODE_LSB+:2] : s.mode[i]) == DMACE_MODE_BLOCK;
            ctl[i].src        = (wr_ch[i] && wb_sel_i[0])
                              ? wb_dat_i[DMACE_SRC_LSB+:2] : s.src[i];
            // Locked out while the system error flag stands
            ctl[i].en_set     = wr_ch[i] && wb_sel_i[3]
                              && wb_dat_i[DMACE_ENABLE_BIT] && !s.err_flag;
            ctl[i].en_clr     = wr_ch[i] && wb_sel_i[3]
                              && !wb_dat_i[DMACE_ENABLE_BIT] && !s.err_flag;
            ch_req[i]         = (s.src[i] == DMACE_SRC_MODULE) ? module_req_i[i]
                              : (s.src[i] == DMACE_SRC_AUTO)   ? 1'b0
                              : ext_req_i[i];
        end
    end

    // Channel instances
    for (genvar g = 0; g < DMACE_NUM_CH; g++) begin : g_ch
        dmace_chan u_chan (
            .clk_i    (clk_i),
            .srst_i   (srst_i),
            .ctl_i    (ctl[g]),
            .req_i    (ch_req[g]),
            .evt_i    (evt_i[g]),
            .halt_i   (halt),
            .enable_o (chan_enable_o[g]),
            .active_o (chan_active_o[g]),
            .stop_o   (ch_stop[g])
        );
    end

    // Register file next state; hardware set wins over software clear
    always_comb begin
        next_s     = s;
        next_s.ack = req_new;
        if (req_new) begin
            next_s.rdata = read_word(word_idx, s, chan_enable_o, chan_active_o);
        end
        if (wr_fire) begin
            if (word_idx < 3'(DMACE_NUM_CH)) begin
                // Mode and source are not guarded against change while enabled
                if (wb_sel_i[1]) begin
                    next_s.mode[word_idx[1:0]] =
                        wb_dat_i[DMACE_MODE_LSB+1:DMACE_MODE_LSB];
                end
                if (wb_sel_i[0]) begin
                    next_s.src[word_idx[1:0]] = wb_dat_i[DMACE_SRC_LSB+1:DMACE_SRC_LSB];
                end
                if (word_idx == 3'h0 && wb_sel_i[2] && !wb_dat_i[DMACE_SYSTEM_ERROR_FLAG_BIT]) begin
                    next_s.err_flag = 1'b0;
                end
            end else if (word_idx == DMACE_OFS_STAT[4:2] && wb_sel_i[0]) begin
                next_s.irq_stat = s.irq_stat & ~wb_dat_i[DMACE_NUM_CH-1:0];
            end else if (word_idx == DMACE_OFS_MASK[4:2] && wb_sel_i[0]) begin
                next_s.irq_mask = wb_dat_i[DMACE_NUM_CH-1:0];
            end
        end
        // Sticky sets applied last so a same-cycle clear loses
        if (sys_err) begin
            next_s.err_flag = 1'b1;
        end
        next_s.irq_stat = next_s.irq_stat | ch_stop;
    end

    // Register update
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '{ack: 1'b0, rdata: 32'h0000_0000, err_flag: 1'b0,
                   irq_stat: DMACE_IRQ_RST, irq_mask: DMACE_IRQ_RST,
                   mode: {DMACE_NUM_CH{DMACE_MODE_RST}},
                   src: {DMACE_NUM_CH{DMACE_SRC_RST}}};
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign irq_o    = |(s.irq_stat & s.irq_mask);

    a_err_lock: assert property (@(posedge clk_i) disable iff (srst_i)
        s.err_flag && wr_fire && wb_sel_i[3] && !halt && evt_i == '0
        |=> chan_enable_o == $past(chan_enable_o)) else $error("enable changed under error");
    a_sys_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        sys_err |=> chan_enable_o == '0 && s.err_flag) else $error("system error not handled");
    a_standby_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        standby_i [*2] |-> chan_enable_o == '0) else $error("enable set in standby");
    a_ack_timing: assert property (@(posedge clk_i) disable iff (srst_i)
        req_new |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
    a_irq_level: assert property (@(posedge clk_i) disable iff (srst_i)
        (|ch_stop) && ((ch_stop & s.irq_mask) != '0) |=> irq_o) else $error("irq not raised");

endmodule : dmace_top

// ### dmace_src_model.sv
// Purpose: Request source model standing beside the transfer-enable control
// Assumes: Bench holds ext_i and ch_i steady until the request has gone out
// Notes:   The delay input lets one source answer promptly or slowly
`timescale 1ns/100ps
module dmace_src_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Command from the bench
    input  wire logic       go_i,
    input  wire logic       ext_i,
    input  wire logic [3:0] ch_i,
    input  wire logic [3:0] dly_i,
    // Requests towards the block
    output logic [3:0]      module_req_o,
    output logic [3:0]      ext_req_o
);
    logic [3:0] cnt;

    // One request pulse per command with dly_i below 15, after dly_i + 1 idle cycles
    always_ff @(posedge clk_i) begin
        module_req_o <= 4'h0;
        ext_req_o    <= 4'h0;
        if (srst_i) begin
            cnt <= 4'h0;
        end else if (go_i) begin
            cnt <= dly_i + 4'h1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                if (ext_i) ext_req_o <= ch_i;
                else module_req_o <= ch_i;
            end
        end
    end
endmodule : dmace_src_model

// ### dma_channel_transfer_enable_tb.sv
// Purpose: Self-checking bench of the four-channel transfer-enable control
// Assumes: Classic Wishbone, ack one cycle after the request is taken
// Notes:   Each scenario is its own task and judges its own results
`timescale 1ns/100ps
module dma_channel_transfer_enable_tb;
    import dmace_pkg::*;
    logic clk_i = 1'b0, srst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0, mreq, xreq, ch_m = 4'h0, dly = 4'h0, en, act;
    logic [31:0] wb_wdat = 32'h0, wb_rdat;
    logic go = 1'b0, ext = 1'b0, addr_err = 1'b0, nmi = 1'b0, standby = 1'b0, irq;
    dmace_evt_t [3:0] evt = '0;
    int miscompares = 0, compares = 0, cyc_cnt = 0;

    dmace_top uut (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .module_req_i(mreq), .ext_req_i(xreq),
        .evt_i(evt), .addr_err_i(addr_err), .nmi_i(nmi), .standby_i(standby),
        .chan_enable_o(en), .chan_active_o(act), .irq_o(irq));
    dmace_src_model src (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .ext_i(ext), .ch_i(ch_m),
        .dly_i(dly), .module_req_o(mreq), .ext_req_o(xreq));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("miscompares %0d compares %0d", miscompares, compares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // Hang guard, well above the few hundred cycles the scenarios need
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Single classic cycle; request held until ack is sampled high
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t no ack from the register bus", $time);
        end
        rd = wb_rdat;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(a, 1'b1, d, 4'hf, rd);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(a, 1'b0, 32'h0, 4'hf, rd);
        chk(rd, exp);
    endtask : rchk

    function automatic logic [31:0] creg(logic e, logic blk, logic [1:0] s);
        creg = 32'h0;
        creg[DMACE_ENABLE_BIT] = e;
        creg[DMACE_MODE_LSB +: 2] = blk ? DMACE_MODE_BLOCK : DMACE_MODE_NORMAL;
        creg[DMACE_SRC_LSB +: 2] = s;
    endfunction : creg

    // Mode and source are only written together with enable, never changed while running
    task automatic cfg(input int c, input logic e, input logic blk, input logic [1:0] s);
        wr(8'(4 * c), creg(e, blk, s));
    endtask : cfg

    task automatic pulse(input int c, input logic [5:0] e);
        @(posedge clk_i) evt[c] <= dmace_evt_t'(e);
        @(posedge clk_i) evt[c] <= '0;
    endtask : pulse

    task automatic req(input logic x, input logic [3:0] m, input logic [3:0] d);
        @(posedge clk_i) {go, ext, ch_m, dly} <= {1'b1, x, m, d};
        @(posedge clk_i) go <= 1'b0;
    endtask : req

    task automatic t_reset();
        for (int c = 0; c < 8; c++) rchk(8'(4 * c), 32'h0);
        wr(8'h18, 32'hffffffff);
        rchk(8'h18, 32'h0);
        rchk(DMACE_OFS_MASK, 32'h0);
        chk(en, 0);
    endtask : t_reset

    task automatic t_auto();
        cfg(0, 1'b1, 1'b0, DMACE_SRC_AUTO);
        tick(1); chk(en[0], 1);
        tick(1); chk(act[0], 1);
        rchk(8'h00, creg(1'b1, 1'b0, DMACE_SRC_AUTO) | (32'h1 << DMACE_ACTIVE_BIT));
        cfg(0, 1'b0, 1'b0, DMACE_SRC_AUTO);
        tick(2); chk({en[0], act[0]}, 0);
        rchk(DMACE_OFS_STAT, 32'h0);
    endtask : t_auto

    task automatic t_request();
        req(1'b0, 4'h2, 4'h0);
        tick(4); chk(act[1], 0);
        cfg(1, 1'b1, 1'b0, DMACE_SRC_MODULE);
        req(1'b0, 4'h2, 4'h3);
        tick(3); chk(act[1], 0);
        tick(3); chk(act[1], 1);
        pulse(1, 6'h20);
        tick(1); chk({en[1], act[1]}, 2'b10);
        cfg(1, 1'b0, 1'b0, DMACE_SRC_MODULE);
    endtask : t_request

    // Each hardware stop on its own channel and source; channel 3 masked
    task automatic t_stops();
        wr(DMACE_OFS_MASK, 32'h7);
        for (int i = 0; i < 4; i++) begin
            cfg(i, 1'b1, 1'b0, 2'(i));
            if (i != 0) req(i >= 2, 4'h1 << i, 4'h0);
            tick(3); chk(act[i], 1);
            pulse(i, 6'h1 << i);
            tick(1); chk({en[i], act[i]}, 0);
            tick(2); chk(irq, i < 3);
            rchk(DMACE_OFS_STAT, 32'h1 << i);
            wr(DMACE_OFS_STAT, 32'h1 << i);
            tick(2); chk(irq, 0);
        end
    endtask : t_stops

    task automatic t_block();
        cfg(0, 1'b1, 1'b1, DMACE_SRC_AUTO);
        tick(2);
        cfg(0, 1'b0, 1'b1, DMACE_SRC_AUTO);
        tick(3); chk(en[0], 1);
        pulse(0, 6'h10);
        tick(1); chk(en[0], 0);
        rchk(DMACE_OFS_STAT, 32'h0);
    endtask : t_block

    task automatic t_system();
        logic [31:0] rd;
        cfg(0, 1'b1, 1'b0, DMACE_SRC_AUTO);
        cfg(1, 1'b1, 1'b0, DMACE_SRC_AUTO);
        @(posedge clk_i) addr_err <= 1'b1;
        @(posedge clk_i) addr_err <= 1'b0;
        tick(1); chk(en, 0);
        rchk(8'h00, 32'h1 << DMACE_SYSTEM_ERROR_FLAG_BIT);
        cfg(2, 1'b1, 1'b0, DMACE_SRC_AUTO);
        tick(1); chk(en[2], 0);
        bus(8'h00, 1'b1, 32'h0, 4'h4, rd);
        cfg(2, 1'b1, 1'b0, DMACE_SRC_AUTO);
        tick(1); chk(en[2], 1);
        @(posedge clk_i) nmi <= 1'b1;
        @(posedge clk_i) nmi <= 1'b0;
        tick(1); chk(en, 0);
        bus(8'h00, 1'b1, 32'h0, 4'h4, rd);
        wr(DMACE_OFS_STAT, 32'hf);
    endtask : t_system

    task automatic t_standby_race();
        cfg(3, 1'b1, 1'b0, DMACE_SRC_AUTO);
        @(posedge clk_i) standby <= 1'b1;
        tick(2); chk(en[3], 0);
        cfg(3, 1'b1, 1'b0, DMACE_SRC_AUTO);
        tick(1); chk(en[3], 0);
        @(posedge clk_i) standby <= 1'b0;
        // Stop pulse lands on the very edge that applies the write of 1
        fork
            cfg(2, 1'b1, 1'b0, DMACE_SRC_MODULE);
            begin
                tick(2);
                evt[2] <= dmace_evt_t'(6'h01);
                tick(1);
                evt[2] <= '0;
            end
        join
        tick(1); chk(en[2], 0);
    endtask : t_standby_race

    // Main sequence
    initial begin
        tick(10);
        srst_i <= 1'b0;
        tick(1);
        t_reset();
        t_auto();
        t_request();
        t_stops();
        t_block();
        t_system();
        t_standby_race();
        complete_run();
    end
endmodule : dma_channel_transfer_enable_tb
